/* File: hw/i2cb_top.sv */
// two-wire bus controller slice: register port, baud generator and slave address matcher
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module i2cb_top (
    input  wire logic                          ref_clk,
    input  wire logic                          sys_rst,
    input  wire logic [i2cb_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [i2cb_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [i2cb_pkg::DATA_W-1:0]   reg_rdata,
    input  wire logic                          rx_valid,
    input  wire logic [7:0]                    rx_byte,
    input  wire logic                          rx_second,
    output logic                               addr_ack,
    output logic                               addr_match,
    output logic                               gcall_hit,
    output logic                               scl_o,
    output logic                               scl_oe,
    output logic                               baud_tick
);
    import i2cb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // register file

    logic [DATA_W-1:0] ctrl_lo_q;
    logic [DATA_W-1:0] ctrl_hi_q;
    logic [BAUD_W-1:0] baud_reload_value_q;
    logic [SADR_W-1:0] own_addr_q;
    logic [SADR_W-1:0] slave_address_mask_q;
    logic              stat_match_q;
    logic              stat_gcall_q;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] stat_word;

    wire wr_ctrl_lo = reg_wr && (reg_addr == REG_CTRL_LO);
    wire wr_ctrl_hi = reg_wr && (reg_addr == REG_CTRL_HI);
    wire wr_baud    = reg_wr && (reg_addr == REG_BAUD);
    wire wr_sadr    = reg_wr && (reg_addr == REG_SADR);
    wire wr_mask    = reg_wr && (reg_addr == REG_MASK);
    wire wr_stat    = reg_wr && (reg_addr == REG_STAT);

    wire master_en           = ctrl_lo_q[CTL_MASTER_EN];
    wire ten_bit             = ctrl_lo_q[CTL_TEN_BIT];
    wire general_call_enable = ctrl_lo_q[CTL_GENERAL_CALL_ENABLE];
    wire reserved_enforce_a  = ctrl_hi_q[CTH_ENFORCE];

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_lo_q            <= CTRL_LO_RST;
            ctrl_hi_q            <= CTRL_HI_RST;
            baud_reload_value_q  <= BAUD_RST;
            own_addr_q           <= SADR_RST;
            slave_address_mask_q <= MASK_RST;
        end else begin
            if (wr_ctrl_lo) ctrl_lo_q <= reg_wdata;
            if (wr_ctrl_hi) ctrl_hi_q <= reg_wdata;
            if (wr_baud)    baud_reload_value_q <= reg_wdata;
            if (wr_sadr)    own_addr_q <= reg_wdata[SADR_W-1:0];
            if (wr_mask)    slave_address_mask_q <= reg_wdata[SADR_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // baud generator; the pin is open drain, so only the low phase drives

    logic scl_phase;

    i2cb_baud u_baud (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .run     (master_en),
        .reload  (baud_reload_value_q),
        .phase_q (scl_phase),
        .tick    (baud_tick)
    );

    assign scl_o  = 1'b0;
    assign scl_oe = master_en && !scl_phase;

    ////////////////////////////////////////////////////////////////////////////
    // address match decode

    wire [6:0]        addr7    = rx_byte[7:1];
    wire              rw_bit   = rx_byte[0];
    // reserved_enforce_a mode turns every mask bit off
    wire [SADR_W-1:0] mask_eff = reserved_enforce_a ? '0 : slave_address_mask_q;
    wire              first    = rx_valid && !rx_second;

    wire is_gcall  = (addr7 == GCALL_ADDR) && !rw_bit;
    wire up_pat    = (addr7[6:2] == TEN_UP_PAT);
    // start byte, cbus, reserved and high-speed codes share the all-zero top nibble
    wire res7      = ((addr7[6:3] == RES_LO_PAT) && !is_gcall) || (addr7[6:2] == RES_HI_PAT);

    wire [6:0] diff7   = (addr7 ^ own_addr_q[6:0]) & ~mask_eff[6:0];
    wire [1:0] diff_up = (addr7[1:0] ^ own_addr_q[9:8]) & ~mask_eff[9:8];
    wire [7:0] diff_lo = (rx_byte ^ own_addr_q[7:0]) & ~mask_eff[7:0];

    i2cb_am_e am_q;
    i2cb_am_e am_d;

    wire seven_hit = first && !ten_bit && !res7 && !up_pat && !is_gcall && (diff7 == '0);
    wire upper_hit = first && ten_bit && up_pat && (diff_up == '0);
    wire low_hit   = rx_valid && rx_second && (am_q == AM_UPPER) && (diff_lo == '0);
    wire gc_ack    = first && is_gcall && general_call_enable;

    wire match_d = seven_hit || upper_hit || low_hit;
    wire ack_d   = match_d || gc_ack;

    // a write-direction upper byte opens the wait for the low address byte
    always_comb begin
        am_d = am_q;
        unique case (am_q)
            AM_IDLE: begin
                if (upper_hit && !rw_bit) am_d = AM_UPPER;
            end
            AM_UPPER: begin
                if (rx_valid && rx_second) am_d = AM_IDLE;
                else if (first && !(upper_hit && !rw_bit)) am_d = AM_IDLE;
            end
            default: am_d = AM_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            am_q       <= AM_IDLE;
            addr_ack   <= 1'b0;
            addr_match <= 1'b0;
            gcall_hit  <= 1'b0;
        end else begin
            am_q       <= am_d;
            addr_ack   <= ack_d;
            addr_match <= match_d;
            gcall_hit  <= gc_ack;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky match and general-call status, write one to clear; a new event in the clearing cycle wins

    wire clr_match = wr_stat && reg_wdata[STAT_MATCH];
    wire clr_gcall = wr_stat && reg_wdata[STAT_GCALL];

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_match_q <= 1'b0;
            stat_gcall_q <= 1'b0;
        end else begin
            stat_match_q <= match_d || (stat_match_q && !clr_match);
            stat_gcall_q <= gc_ack || (stat_gcall_q && !clr_gcall);
        end
    end

    always_comb begin
        stat_word             = RDATA_IDLE;
        stat_word[STAT_MATCH] = stat_match_q;
        stat_word[STAT_GCALL] = stat_gcall_q;
        stat_word[STAT_UPPER] = (am_q == AM_UPPER);
        stat_word[STAT_PHASE] = scl_phase;
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port: data stand only in the cycle after the strobe, unmapped reads zero

    wire [DATA_W-1:0] sadr_word = {{(DATA_W-SADR_W){1'b0}}, own_addr_q};
    wire [DATA_W-1:0] mask_word = {{(DATA_W-SADR_W){1'b0}}, slave_address_mask_q};

    always_comb begin
        rdata_d = RDATA_IDLE;
        if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL_LO: rdata_d = ctrl_lo_q;
                REG_CTRL_HI: rdata_d = ctrl_hi_q;
                REG_BAUD:    rdata_d = baud_reload_value_q;
                REG_SADR:    rdata_d = sadr_word;
                REG_MASK:    rdata_d = mask_word;
                REG_STAT:    rdata_d = stat_word;
                default:     rdata_d = RDATA_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) rdata_q <= RDATA_IDLE;
        else         rdata_q <= rdata_d;
    end

    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_mask_dontcare;
        first && !ten_bit && !reserved_enforce_a && !res7 && !up_pat && !is_gcall
            && (((addr7 ^ own_addr_q[6:0]) & ~slave_address_mask_q[6:0]) == 7'h00)
        |=> addr_ack && addr_match;
    endproperty
    a_mask_dontcare: assert property (p_mask_dontcare) else $error("masked address not matched");

    property p_reserved_enforce_a_exact;
        first && !ten_bit && reserved_enforce_a && (addr7 != own_addr_q[6:0]) |=> !addr_match;
    endproperty
    a_reserved_enforce_a_exact: assert property (p_reserved_enforce_a_exact) else $error("mask honoured in reserved_enforce_a mode");

    property p_reserved;
        first && (((addr7[6:3] == RES_LO_PAT) && ((addr7 != GCALL_ADDR) || rw_bit))
            || (addr7[6:2] == RES_HI_PAT))
        |=> !addr_ack && !addr_match;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved address acknowledged");

    property p_gcall;
        first && (rx_byte == 8'h00) |=> addr_ack == $past(general_call_enable) && gcall_hit == addr_ack;
    endproperty
    a_gcall: assert property (p_gcall) else $error("general call answer does not follow enable");

    property p_upper_seven;
        first && !ten_bit && (addr7[6:2] == TEN_UP_PAT) |=> !addr_ack;
    endproperty
    a_upper_seven: assert property (p_upper_seven) else $error("upper pattern matched in seven-bit mode");

    property p_low_needs_upper;
        rx_valid && rx_second && !$past(upper_hit && !rw_bit) && (am_q == AM_IDLE) |=> !addr_match;
    endproperty
    a_low_needs_upper: assert property (p_low_needs_upper) else $error("low byte matched without upper");

    property p_scl_drive;
        master_en ##1 master_en |-> scl_oe == !scl_phase;
    endproperty
    a_scl_drive: assert property (p_scl_drive) else $error("pin drive does not follow clock phase");

    property p_sticky_set_wins;
        match_d && clr_match |=> stat_match_q;
    endproperty
    a_sticky_set_wins: assert property (p_sticky_set_wins) else $error("match event lost on clear");

    // these restate the matching rules without the decode wires, save up_pat in p_ten_no_seven, so a slip in the decode shows up here
    property p_ten_no_seven;
        first && ten_bit && !up_pat |=> !addr_match;
    endproperty
    a_ten_no_seven: assert property (p_ten_no_seven) else $error("seven-bit match in ten-bit mode");

    property p_upper_dontcare;
        first && ten_bit && !reserved_enforce_a && (addr7[6:2] == TEN_UP_PAT)
            && (((addr7[1:0] ^ own_addr_q[9:8]) & ~slave_address_mask_q[9:8]) == 2'b00)
        |=> addr_ack && addr_match;
    endproperty
    a_upper_dontcare: assert property (p_upper_dontcare) else $error("masked upper byte not matched");

    property p_low_dontcare;
        rx_valid && rx_second && (am_q == AM_UPPER) && !reserved_enforce_a
            && (((rx_byte ^ own_addr_q[7:0]) & ~slave_address_mask_q[7:0]) == 8'h00)
        |=> addr_ack && addr_match;
    endproperty
    a_low_dontcare: assert property (p_low_dontcare) else $error("masked low byte not matched");

    property p_reserved_enforce_a_upper;
        first && ten_bit && reserved_enforce_a && (addr7[1:0] != own_addr_q[9:8]) |=> !addr_match;
    endproperty
    a_reserved_enforce_a_upper: assert property (p_reserved_enforce_a_upper) else $error("mask honoured on upper byte");

    property p_reserved_enforce_a_low;
        rx_valid && rx_second && reserved_enforce_a && (rx_byte != own_addr_q[7:0]) |=> !addr_match;
    endproperty
    a_reserved_enforce_a_low: assert property (p_reserved_enforce_a_low) else $error("mask honoured on low byte");

    property p_read_no_arm;
        first && rw_bit |=> am_q == AM_IDLE;
    endproperty
    a_read_no_arm: assert property (p_read_no_arm) else $error("read-direction byte armed low byte");

    property p_gcall_apart;
        gcall_hit |-> addr_ack && !addr_match;
    endproperty
    a_gcall_apart: assert property (p_gcall_apart) else $error("general call counted as own match");

    property p_ack_source;
        addr_ack |-> addr_match || gcall_hit;
    endproperty
    a_ack_source: assert property (p_ack_source) else $error("acknowledge without a match");

    property p_scl_idle;
        !master_en |-> !scl_oe;
    endproperty
    a_scl_idle: assert property (p_scl_idle) else $error("clock line driven while master off");

    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == RDATA_IDLE;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside the read cycle");

    c_gcall_ack:  cover property (first && is_gcall && general_call_enable ##1 addr_ack);
    c_ten_low:    cover property (upper_hit && !rw_bit ##[1:8] low_hit ##1 addr_match);
    c_masked_hit: cover property (seven_hit && (diff7 != (addr7 ^ own_addr_q[6:0])));
    c_reserved_enforce_a_rej: cover property (first && reserved_enforce_a && (slave_address_mask_q != '0) ##1 !addr_ack);

endmodule // i2cb_top
`default_nettype wire

/* File: inc/i2cb_pkg.sv */
// constants, register map and types shared by the baud generator and address matcher
package i2cb_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 3;
    localparam int BAUD_W = 16;
    localparam int SADR_W = 10;

    // register indices on the plain register port
    localparam logic [ADDR_W-1:0] REG_CTRL_LO = 3'h0;
    localparam logic [ADDR_W-1:0] REG_CTRL_HI = 3'h1;
    localparam logic [ADDR_W-1:0] REG_BAUD    = 3'h2;
    localparam logic [ADDR_W-1:0] REG_SADR    = 3'h3;
    localparam logic [ADDR_W-1:0] REG_MASK    = 3'h4;
    localparam logic [ADDR_W-1:0] REG_STAT    = 3'h5;

    // field positions
    localparam int CTL_MASTER_EN = 0;
    localparam int CTL_TEN_BIT   = 1;
    localparam int CTL_GENERAL_CALL_ENABLE      = 7;
    localparam int CTH_ENFORCE   = 11;
    localparam int STAT_MATCH    = 0;
    localparam int STAT_GCALL    = 1;
    localparam int STAT_UPPER    = 2;
    localparam int STAT_PHASE    = 3;

    // reset values
    localparam logic [DATA_W-1:0] CTRL_LO_RST = 16'h0000;
    localparam logic [DATA_W-1:0] CTRL_HI_RST = 16'h0000;
    localparam logic [BAUD_W-1:0] BAUD_RST    = 16'h0000;
    localparam logic [SADR_W-1:0] SADR_RST    = 10'h000;
    localparam logic [SADR_W-1:0] MASK_RST    = 10'h000;
    localparam logic [DATA_W-1:0] RDATA_IDLE  = 16'h0000;

    // address patterns on the seven-bit field of a first byte
    localparam logic [4:0] TEN_UP_PAT = 5'h1E;
    localparam logic [4:0] RES_HI_PAT = 5'h1F;
    localparam logic [3:0] RES_LO_PAT = 4'h0;
    localparam logic [6:0] GCALL_ADDR = 7'h00;

    // cycles added to the reload value for each half period
    localparam logic [BAUD_W:0] HALF_EXTRA = 17'h00002;

    typedef enum logic [1:0] {
        AM_IDLE  = 2'b01,
        AM_UPPER = 2'b10
    } i2cb_am_e;

endpackage

/* File: hw/i2cb_baud.sv */
// master-mode serial clock generator counting instruction clock cycles
`timescale 1ns/1ps
`default_nettype none
module i2cb_baud (
    input  wire logic                          ref_clk,
    input  wire logic                          sys_rst,
    input  wire logic                          run,
    input  wire logic [i2cb_pkg::BAUD_W-1:0]   reload,
    output logic                               phase_q,
    output logic                               tick
);
    import i2cb_pkg::*;

    logic [BAUD_W:0] cnt_q;
    logic [BAUD_W:0] cnt_d;
    logic [BAUD_W:0] load_val;
    logic            phase_d;

    // one count of reload+2 cycles per half period; 17 bits so full-scale reload cannot wrap
    assign load_val = {1'b0, reload} + HALF_EXTRA - 17'h00001;
    assign tick     = run && (cnt_q == '0);
    assign cnt_d    = (!run || tick) ? load_val : cnt_q - 17'h00001;
    // line is released high while the generator is stopped
    assign phase_d  = !run ? 1'b1 : (tick ? !phase_q : phase_q);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q   <= '0;
            phase_q <= 1'b1;
        end else begin
            cnt_q   <= cnt_d;
            phase_q <= phase_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    logic [BAUD_W:0] since_q;
    logic            steady_q;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            since_q  <= '0;
            steady_q <= 1'b0;
        end else begin
            since_q  <= tick ? '0 : since_q + 17'h00001;
            steady_q <= tick ? (run && $stable(reload)) : (steady_q && run && $stable(reload));
        end
    end

    property p_half_period;
        tick && steady_q |-> since_q == {1'b0, reload} + HALF_EXTRA - 17'h00001;
    endproperty
    a_half_period: assert property (p_half_period) else $error("half period not reload plus two");

    property p_phase_toggle;
        run && tick |=> phase_q != $past(phase_q);
    endproperty
    a_phase_toggle: assert property (p_phase_toggle) else $error("phase did not toggle on expiry");

    property p_phase_hold;
        run && !tick |=> phase_q == $past(phase_q);
    endproperty
    a_phase_hold: assert property (p_phase_hold) else $error("phase changed between expiries");

    c_tick_min: cover property (run && reload == '0 && tick ##2 tick);

endmodule // i2cb_baud
`default_nettype wire

/* File: tb/i2cb_peer.sv */
// bus peer model that presents received address bytes to the slave matcher
`timescale 1ns/1ps
`default_nettype none
module i2cb_peer (
    input  wire logic       ref_clk,
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    output logic            rx_second,
    input  wire logic       addr_ack,
    input  wire logic       addr_match,
    input  wire logic       gcall_hit
);
    initial begin
        rx_valid  = 1'b0;
        rx_byte   = 8'hA5;
        rx_second = 1'b0;
    end

    // one byte per call; the released lines show the inverse so stale values never look valid
    task automatic send(input logic [7:0] b, input logic sec, output logic [2:0] seen);
        @(posedge ref_clk);
        rx_valid  <= 1'b1;
        rx_byte   <= b;
        rx_second <= sec;
        @(posedge ref_clk);
        rx_valid  <= 1'b0;
        rx_byte   <= ~b;
        rx_second <= ~sec;
        #1 seen = {addr_ack, addr_match, gcall_hit};
    endtask
endmodule // i2cb_peer
`default_nettype wire

/* File: tb/tb_i2cb_top.sv */
// self-checking bench: register port, address matcher and baud generator
`timescale 1ns/1ps
`default_nettype none
module tb_i2cb_top;
    import i2cb_pkg::*;

    logic              ref_clk   = 1'b0;
    logic              sys_rst   = 1'b1;
    logic [ADDR_W-1:0] reg_addr  = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic              reg_wr    = 1'b0;
    logic              reg_rd    = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic              rx_valid, rx_second, addr_ack, addr_match, gcall_hit;
    logic [7:0]        rx_byte;
    logic              scl_o, scl_oe, baud_tick;
    int                failures  = 0;
    int                compares  = 0;
    logic [15:0]       v;

    i2cb_top DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .rx_second(rx_second), .addr_ack(addr_ack), .addr_match(addr_match), .gcall_hit(gcall_hit),
        .scl_o(scl_o), .scl_oe(scl_oe), .baud_tick(baud_tick));

    i2cb_peer peer (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_second(rx_second),
        .addr_ack(addr_ack), .addr_match(addr_match), .gcall_hit(gcall_hit));

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // returns {ack, match, gcall} seen in the cycle after the byte
    task automatic am(input logic [7:0] b, input logic sec, output logic [15:0] r);
        logic [2:0] s;
        peer.send(b, sec, s);
        r = {13'h0000, s};
    endtask

    // spacing of ticks and duty of the clock drive over one full period
    task automatic baud(input int r);
        int n;
        int hi;
        wr(REG_CTRL_LO, 16'h0000);
        wr(REG_BAUD, 16'(r));
        wr(REG_CTRL_LO, 16'h0001);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (baud_tick !== 1'b1 && n < 200);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (baud_tick !== 1'b1 && n < 200);
        chk(16'(n), 16'(r + 2));
        hi = 0;
        repeat (2 * (r + 2)) begin
            @(negedge ref_clk);
            hi += (scl_oe === 1'b1) ? 1 : 0;
        end
        chk(16'(hi), 16'(r + 2));
        chk(16'(scl_o), 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        close_out();
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), v);
            chk(v, (3'(i) == REG_STAT) ? 16'(1 << STAT_PHASE) : 16'h0000);
        end
        wr(REG_SADR, 16'h002A);
        am(8'h54, 1'b0, v); chk(v, 16'h0006);
        am(8'h56, 1'b0, v); chk(v, 16'h0000);
        wr(REG_MASK, 16'h0001);
        am(8'h57, 1'b0, v); chk(v, 16'h0006);
        wr(REG_CTRL_HI, 16'h0800);
        am(8'h56, 1'b0, v); chk(v, 16'h0000);
        wr(REG_CTRL_HI, 16'h0000);
        // every bit don't-care: only reserved patterns may still be turned away
        wr(REG_MASK, 16'h03FF);
        am(8'h80, 1'b0, v); chk(v, 16'h0006);
        for (int a = 1; a < 8; a++) begin
            am({7'(a), 1'b0}, 1'b0, v); chk(v, 16'h0000);
        end
        for (int a = 8'h78; a < 8'h80; a++) begin
            am({7'(a), 1'b1}, 1'b0, v); chk(v, 16'h0000);
        end
        am(8'h00, 1'b0, v); chk(v, 16'h0000);
        wr(REG_CTRL_LO, 16'h0080);
        am(8'h00, 1'b0, v); chk(v, 16'h0005);
        am(8'h01, 1'b0, v); chk(v, 16'h0000);
        // ten-bit own address 2A5 with upper byte then low byte
        wr(REG_MASK, 16'h0000);
        wr(REG_SADR, 16'h02A5);
        wr(REG_CTRL_LO, 16'h0002);
        wr(REG_STAT, 16'h0003);
        am(8'hF4, 1'b0, v); chk(v, 16'h0006);
        rd(REG_STAT, v); chk(v & 16'h0007, 16'h0005);
        am(8'hA5, 1'b1, v); chk(v, 16'h0006);
        am(8'hA5, 1'b1, v); chk(v, 16'h0000);
        am(8'hF6, 1'b0, v); chk(v, 16'h0000);
        wr(REG_MASK, 16'h0001);
        am(8'hF4, 1'b0, v); chk(v, 16'h0006);
        am(8'hA4, 1'b1, v); chk(v, 16'h0006);
        // read-direction upper byte answers but leaves the low byte unarmed
        am(8'hF5, 1'b0, v); chk(v, 16'h0006);
        am(8'hA5, 1'b1, v); chk(v, 16'h0000);
        am(8'h4A, 1'b0, v); chk(v, 16'h0000);
        baud(0);
        baud(3);
        baud(9);
        // reset in mid-run with the generator going
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        #1 chk(16'(scl_oe), 16'h0000);
        rd(REG_CTRL_LO, v); chk(v, 16'h0000);
        close_out();
    end
endmodule // tb_i2cb_top
`default_nettype wire
